// ==== hdl/htu_regs.svh ====
// Register map, field positions, reset values and vectors of the trap unit
// Assumes byte addresses on a 32-bit classic Wishbone bus
`ifndef HTU_REGS_SVH
`define HTU_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HTU_ADR_FLAGS 16'hffac
`define HTU_ADR_LOW_LIMIT 16'hffb0
`define HTU_ADR_HIGH_LIMIT 16'hffb4
`define HTU_ADR_CONTROL 16'hffb8
`define HTU_ADR_STATUS 16'hffbc

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define HTU_BIT_NMI 15
`define HTU_BIT_STACK_OVERFLOW_FLAG 14
`define HTU_BIT_STACK_UNDERFLOW_FLAG 13
`define HTU_BIT_BADOPC 7
`define HTU_BIT_PROT 3
`define HTU_BIT_ODDOPA 2
`define HTU_BIT_ODDBR 1
`define HTU_BIT_NOBUS 0
`define HTU_FLAGS_MASK 16'he08f
`define HTU_CLASS_A_MASK 16'he000
`define HTU_CLASS_B_MASK 16'h008f
`define HTU_FLAGS_RESET 16'h0000

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define HTU_CTL_SEG_EN 0
`define HTU_CTL_EXTBUS_EN 1
`define HTU_CTL_RESET 16'h0000
`define HTU_LIMIT_LOW_RESET 16'h0000
`define HTU_LIMIT_HIGH_RESET 16'hffff

// ----------------------------------------
// Trap entry values
// ----------------------------------------
`define HTU_PRIO_LSB 12
`define HTU_PRIO_MAX 4'hf
`define HTU_SEG_ZERO 8'h00
`define HTU_VEC_NMI 16'h0004
`define HTU_VEC_STACK_OVERFLOW_FLAG 16'h0008
`define HTU_VEC_STACK_UNDERFLOW_FLAG 16'h000c
`define HTU_VEC_CLASS_B 16'h0010

`endif

// ==== hdl/htu_pkg.sv ====
// Types shared by the trap unit
// Assumes htu_regs.svh supplies the numbers
package htu_pkg;

  // Nesting level of trap handlers
  typedef enum logic [1:0] {
    HTU_IDLE = 2'b00,
    HTU_IN_B = 2'b01,
    HTU_IN_A = 2'b10,
    HTU_IN_A_OVER_B = 2'b11
  } htu_nest_t;

endpackage

// ==== hdl/htu_trap_unit.sv ====
// Hardware trap unit: detection, ranking and entry of eight hardware traps
// Assumes a CPU that signals instruction boundaries and return instructions,
// and software on a classic 32-bit Wishbone bus.
`timescale 1ns/1ps
`include "htu_regs.svh"

module htu_trap_unit
  import htu_pkg::*;
(
  input wire logic clk_i, // 50 MHz clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic ce_i, // Clock enable, freezes all state when low
  // Wishbone slave
  input wire logic cyc_i, // Bus cycle
  input wire logic stb_i, // Strobe
  input wire logic we_i, // Write enable
  input wire logic [15:0] adr_i, // Byte address
  input wire logic [3:0] sel_i, // Byte selects
  input wire logic [31:0] dat_i, // Write data
  output logic [31:0] dat_o, // Read data
  output logic ack_o, // Acknowledge
  // External pin
  input wire logic nmi_n_i, // Non-maskable trap pin, falling edge
  // CPU detection inputs
  input wire logic [15:0] stack_pointer_i, // New stack pointer value
  input wire logic sp_dec_i, // Stack pointer decremented this cycle
  input wire logic sp_inc_i, // Stack pointer incremented this cycle
  input wire logic opcode_invalid_i, // Decoded opcode is not valid
  input wire logic prot_fault_i, // Protected instruction malformed
  input wire logic word_access_i, // Word operand read or write
  input wire logic [15:0] operand_adr_i, // Operand byte address
  input wire logic branch_i, // Branch taken
  input wire logic [15:0] branch_target_i, // Branch target address
  input wire logic ext_access_i, // External bus access request
  // CPU sequencing
  input wire logic boundary_i, // Instruction boundary
  input wire logic return_i, // Return-from-interrupt executed
  input wire logic [15:0] processor_status_word_i, // Current status word
  input wire logic [15:0] instruction_pointer_i, // Next instruction pointer
  input wire logic [15:0] fault_ip_i, // Pointer of instruction being decoded
  input wire logic [7:0] code_segment_pointer_i, // Current code segment
  // Trap entry outputs
  output logic trap_req_o, // Trap pending, stalls normal sequencing
  output logic trap_take_o, // Trap entry pulse
  output logic cancel_o, // Cancel faulting instruction at entry
  output logic [15:0] trap_vector_o, // Branch target
  output logic [15:0] push_psw_o, // Status word to push
  output logic [15:0] push_ip_o, // Pointer to push
  output logic [7:0] push_csp_o, // Code segment to push
  output logic push_csp_en_o, // Push code segment too
  output logic [15:0] new_psw_o, // Status word for the handler
  output logic [7:0] new_csp_o // Code segment for the handler
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] trap_request_flags;
  logic [15:0] stack_low_limit;
  logic [15:0] stack_high_limit;
  logic [15:0] control;
  htu_nest_t nest;
  htu_nest_t next_nest;
  logic nmi_s1;
  logic nmi_s2;
  logic nmi_s3;
  logic [15:0] bad_opc_ip;

  // Word write merge with byte selects
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] sl);
    merge16 = {sl[1] ? wd[15:8] : old[15:8], sl[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Fixed internal ranking of the first class
  function automatic logic [15:0] class_a_vector(input logic [15:0] f);
    if (f[`HTU_BIT_NMI])
      class_a_vector = `HTU_VEC_NMI;
    else if (f[`HTU_BIT_STACK_OVERFLOW_FLAG])
      class_a_vector = `HTU_VEC_STACK_OVERFLOW_FLAG;
    else
      class_a_vector = `HTU_VEC_STACK_UNDERFLOW_FLAG;
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire bus_req = cyc_i && stb_i && !ack_o;
  wire bus_wr = bus_req && we_i;
  wire sel_flags = adr_i == `HTU_ADR_FLAGS;
  wire sel_low = adr_i == `HTU_ADR_LOW_LIMIT;
  wire sel_high = adr_i == `HTU_ADR_HIGH_LIMIT;
  wire sel_ctl = adr_i == `HTU_ADR_CONTROL;
  wire sel_stat = adr_i == `HTU_ADR_STATUS;
  wire [15:0] status_word = {14'h0000, nest};
  wire [15:0] read_word =
    sel_flags ? trap_request_flags :
    sel_low ? stack_low_limit :
    sel_high ? stack_high_limit :
    sel_ctl ? control :
    sel_stat ? status_word : 16'h0000;

  // ----------------------------------------
  // Trap detection
  // ----------------------------------------
  wire seg_en = control[`HTU_CTL_SEG_EN];
  wire nmi_fall = nmi_s3 && !nmi_s2;
  wire stack_overflow_flag_hit = sp_dec_i && (stack_pointer_i < stack_low_limit);
  wire stack_underflow_flag_hit = sp_inc_i && (stack_pointer_i > stack_high_limit);
  wire oddopa_hit = word_access_i && operand_adr_i[0];
  wire oddbr_hit = branch_i && branch_target_i[0];
  wire nobus_hit = ext_access_i && !control[`HTU_CTL_EXTBUS_EN];

  // One set bit per trap function
  wire [15:0] hw_set = {nmi_fall, stack_overflow_flag_hit, stack_underflow_flag_hit, 5'h00,
    opcode_invalid_i, 3'h0, prot_fault_i, oddopa_hit, oddbr_hit, nobus_hit};

  // Software write, then hardware set wins over a clear
  wire [15:0] sw_flags = (bus_wr && sel_flags) ? merge16(trap_request_flags, dat_i, sel_i) : trap_request_flags;
  wire [15:0] next_flags = (sw_flags | hw_set) & `HTU_FLAGS_MASK;

  // ----------------------------------------
  // Ranking and nesting
  // ----------------------------------------
  // Stored flags are the requests, whoever set them
  wire pend_a = |(trap_request_flags & `HTU_CLASS_A_MASK);
  wire pend_b = |(trap_request_flags & `HTU_CLASS_B_MASK);
  wire a_busy = (nest == HTU_IN_A) || (nest == HTU_IN_A_OVER_B);
  wire take_a = pend_a && !a_busy;
  wire take_b = pend_b && (nest == HTU_IDLE) && !take_a;
  wire take = boundary_i && (take_a || take_b);
  wire undo_b_ip = !take_a && trap_request_flags[`HTU_BIT_BADOPC];

  always_comb
  begin
    next_nest = nest;
    case (nest)
      HTU_IDLE:
      begin
        if (take && take_a)
          next_nest = HTU_IN_A;
        else if (take)
          next_nest = HTU_IN_B;
      end
      HTU_IN_B:
      begin
        if (take && take_a)
          next_nest = HTU_IN_A_OVER_B;
        else if (return_i)
          next_nest = HTU_IDLE;
      end
      HTU_IN_A:
      begin
        if (return_i)
          next_nest = HTU_IDLE;
      end
      HTU_IN_A_OVER_B:
      begin
        if (return_i)
          next_nest = HTU_IN_B;
      end
      default:
        next_nest = HTU_IDLE;
    endcase
  end

  assign trap_req_o = take_a || take_b;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      nmi_s1 <= 1'b1;
      nmi_s2 <= 1'b1;
      nmi_s3 <= 1'b1;
    end
    else if (ce_i)
    begin
      nmi_s1 <= nmi_n_i;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
    end
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      ack_o <= bus_req;
      dat_o <= {16'h0000, read_word};
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trap_request_flags <= `HTU_FLAGS_RESET;
      stack_low_limit <= `HTU_LIMIT_LOW_RESET;
      stack_high_limit <= `HTU_LIMIT_HIGH_RESET;
      control <= `HTU_CTL_RESET;
      nest <= HTU_IDLE;
    end
    else if (ce_i)
    begin
      trap_request_flags <= next_flags;
      nest <= next_nest;
      if (bus_wr && sel_low)
        stack_low_limit <= merge16(stack_low_limit, dat_i, sel_i);
      if (bus_wr && sel_high)
        stack_high_limit <= merge16(stack_high_limit, dat_i, sel_i);
      if (bus_wr && sel_ctl)
        control <= merge16(control, dat_i, sel_i) & 16'h0003;
    end
  end

  // Faulting pointer captured at every invalid opcode and held until the next one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bad_opc_ip <= 16'h0000;
    else if (ce_i && opcode_invalid_i)
      bad_opc_ip <= fault_ip_i;
  end

  // ----------------------------------------
  // Trap entry
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trap_take_o <= 1'b0;
      cancel_o <= 1'b0;
      trap_vector_o <= 16'h0000;
      push_psw_o <= 16'h0000;
      push_ip_o <= 16'h0000;
      push_csp_o <= 8'h00;
      push_csp_en_o <= 1'b0;
      new_psw_o <= 16'h0000;
      new_csp_o <= 8'h00;
    end
    else if (ce_i)
    begin
      trap_take_o <= take;
      if (take)
      begin
        trap_vector_o <= take_a ? class_a_vector(trap_request_flags) : `HTU_VEC_CLASS_B;
        cancel_o <= !take_a;
        push_psw_o <= processor_status_word_i;
        push_ip_o <= undo_b_ip ? bad_opc_ip : instruction_pointer_i;
        push_csp_o <= code_segment_pointer_i;
        push_csp_en_o <= seg_en;
        new_psw_o <= {`HTU_PRIO_MAX, processor_status_word_i[`HTU_PRIO_LSB-1:0]};
        new_csp_o <= seg_en ? `HTU_SEG_ZERO : code_segment_pointer_i;
      end
    end
  end

endmodule

// ==== bench/htu_checker.sv ====
// Port-level checks of the hardware trap unit
// Assumes one clock domain; bound to htu_trap_unit
`timescale 1ns/1ps
module htu_checker(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic ce_i, // Clock enable
  input wire logic cyc_i, // Bus cycle
  input wire logic stb_i, // Strobe
  input wire logic ack_o, // Acknowledge
  input wire logic boundary_i, // Boundary
  input wire logic trap_req_o, // Trap pending
  input wire logic trap_take_o, // Entry pulse
  input wire logic cancel_o, // Cancel
  input wire logic [15:0] trap_vector_o, // Vector
  input wire logic [15:0] push_psw_o, // Pushed word
  input wire logic [15:0] processor_status_word_i, // Status word
  input wire logic push_csp_en_o, // Segment push
  input wire logic [15:0] new_psw_o, // Handler word
  input wire logic [7:0] new_csp_o // Handler segment
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_bus_req;
    cyc_i && stb_i && ce_i && !ack_o;
  endsequence
  sequence s_take_req;
    boundary_i && trap_req_o && ce_i;
  endsequence
  a_ack_next: assert property (s_bus_req |=> ack_o) else $error("no ack after request");
  a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o) else $error("ack longer than one cycle");
  a_take_next: assert property (s_take_req |=> trap_take_o) else $error("pending trap not taken");
  a_take_cause: assert property ($rose(trap_take_o) |-> $past(boundary_i && trap_req_o))
    else $error("entry without pending trap at boundary");
  a_prio_max: assert property (trap_take_o |-> new_psw_o[15:12] == 4'hf)
    else $error("handler priority not 15");
  a_vector_set: assert property (trap_take_o |-> trap_vector_o inside {16'h0004, 16'h0008, 16'h000c, 16'h0010})
    else $error("vector outside trap table");
  a_cancel_class: assert property (trap_take_o |-> cancel_o == (trap_vector_o == 16'h0010))
    else $error("cancel does not match class");
  a_seg_zero: assert property (trap_take_o && push_csp_en_o |-> new_csp_o == 8'h00)
    else $error("segment not forced to zero");
  a_push_psw: assert property (trap_take_o |-> push_psw_o == $past(processor_status_word_i))
    else $error("pushed status word wrong");
endmodule
bind htu_trap_unit htu_checker u_chk(.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .ack_o, .boundary_i, .trap_req_o,
  .trap_take_o, .cancel_o, .trap_vector_o, .push_psw_o, .processor_status_word_i, .push_csp_en_o, .new_psw_o,
  .new_csp_o);

// ==== bench/htu_cpu_model.sv ====
// Behavioural CPU sequencer feeding the trap unit
// Assumes the bench pulses returns and fault detections itself
`timescale 1ns/1ps
module htu_cpu_model(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  output logic boundary_o, // Boundary every fourth cycle
  output logic [15:0] psw_o, // Status word
  output logic [15:0] ip_o, // Next pointer
  output logic [7:0] csp_o // Code segment
);
  logic [1:0] phase;
  assign psw_o = 16'h0123;
  assign csp_o = 8'h05;
  assign boundary_o = phase == 2'h3;
  always_ff @(posedge clk_i)
  begin
    phase <= rst_i ? 2'h0 : phase + 2'h1;
    ip_o <= rst_i ? 16'h0200 : ip_o + {15'h0, boundary_o};
  end
endmodule

// ==== bench/hardware_trap_unit_tb.sv ====
// Self-checking bench of the trap unit over Wishbone
// Assumes the CPU model supplies boundaries; ce_i held high
`timescale 1ns/1ps
module hardware_trap_unit_tb;
  logic clk_i, rst_i, cyc, stb, we, ack_o, nmi_n, ret, bnd, take, cancel, csp_en;
  logic [6:0] det_k;
  logic [15:0] adr, det_v, processor_status_word, ip, vec, last_vec, pip;
  logic [31:0] dat, dat_o, q;
  logic [7:0] code_segment_pointer;
  logic last_cancel;
  int miscompares = 0, comparisons = 0, takes = 0, i;
  htu_cpu_model cpu(.clk_i, .rst_i, .boundary_o(bnd), .psw_o(processor_status_word), .ip_o(ip), .csp_o(code_segment_pointer));
  htu_trap_unit dut(.clk_i, .rst_i, .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'h3), .dat_i(dat), .dat_o, .ack_o, .nmi_n_i(nmi_n), .stack_pointer_i(det_v),
    .sp_dec_i(det_k[0]), .sp_inc_i(det_k[1]), .opcode_invalid_i(det_k[2]), .prot_fault_i(det_k[3]),
    .word_access_i(det_k[4]), .operand_adr_i(det_v), .branch_i(det_k[5]), .branch_target_i(det_v),
    .ext_access_i(det_k[6]), .boundary_i(bnd), .return_i(ret), .processor_status_word_i(processor_status_word),
    .instruction_pointer_i(ip), .fault_ip_i(16'h0abc), .code_segment_pointer_i(code_segment_pointer), .trap_req_o(),
    .trap_take_o(take), .cancel_o(cancel), .trap_vector_o(vec), .push_psw_o(), .push_ip_o(pip),
    .push_csp_o(), .push_csp_en_o(csp_en), .new_psw_o(), .new_csp_o());
  // ----------------------------------------
  // Clock, entry log and bus tasks
  // ----------------------------------------
  initial
  begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (take === 1'b1)
    begin
      takes++;
      last_vec <= vec;
      last_cancel <= cancel;
    end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {16'h0, d};
    i = 0;
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++i < 50);
    if (ack_o !== 1'b1)
    begin
      miscompares++;
      $display("unexpected at %0t: ack %h exp %h", $time, ack_o, 1'b1);
    end
    q = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e);
    wb(0, a, 16'h0);
    chk(q, {16'h0, e});
  endtask
  task expect_take(input int n, input logic [15:0] v);
    i = 0;
    while (takes < n && i < 100) begin @(posedge clk_i); i++; end
    @(posedge clk_i);
    chk(32'(takes), 32'(n));
    chk({16'h0, last_vec}, {16'h0, v});
    chk({31'h0, last_cancel}, {31'h0, v == 16'h0010});
  endtask
  task return_from_service_instr();
    @(posedge clk_i) ret <= 1;
    @(posedge clk_i) ret <= 0;
  endtask
  task detect(input logic [6:0] k, input logic [15:0] v);
    @(posedge clk_i) begin det_k <= k; det_v <= v; end
    @(posedge clk_i) det_k <= 0;
  endtask
  task test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    test_done();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {cyc, stb, we, ret, det_k, adr, dat, det_v} = 0;
    nmi_n = 1; rst_i = 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    rd(16'hffac, 16'h0000); rd(16'hffb0, 16'h0000); rd(16'hffb4, 16'hffff); rd(16'hfff0, 16'h0000);
    wb(1, 16'hffb8, 16'h0001); wb(1, 16'hffb0, 16'h1000); wb(1, 16'hffb4, 16'h2000);
    wb(1, 16'hffac, 16'he001); expect_take(1, 16'h0004);
    chk({31'h0, csp_en}, 32'h1);
    rd(16'hffac, 16'he001);
    wb(1, 16'hffac, 16'h6001); repeat (20) @(posedge clk_i); chk(32'(takes), 32'h1);
    return_from_service_instr(); expect_take(2, 16'h0008);
    wb(1, 16'hffac, 16'h2001); return_from_service_instr(); expect_take(3, 16'h000c);
    wb(1, 16'hffac, 16'h0001); return_from_service_instr(); expect_take(4, 16'h0010);
    nmi_n <= 0; expect_take(5, 16'h0004);
    return_from_service_instr(); expect_take(6, 16'h0004);
    nmi_n <= 1; wb(1, 16'hffac, 16'h0000); return_from_service_instr(); return_from_service_instr();
    detect(7'h01, 16'h0fff); expect_take(7, 16'h0008);
    wb(1, 16'hffac, 16'h0000); return_from_service_instr();
    detect(7'h02, 16'h2001); expect_take(8, 16'h000c);
    wb(1, 16'hffac, 16'h0000); return_from_service_instr();
    detect(7'h10, 16'h0003); expect_take(9, 16'h0010);
    rd(16'hffac, 16'h0004); wb(1, 16'hffac, 16'h0000); return_from_service_instr();
    detect(7'h7c, 16'h0001); expect_take(10, 16'h0010);
    chk({16'h0, pip}, 32'h00000abc);
    rd(16'hffac, 16'h008f); repeat (20) @(posedge clk_i); chk(32'(takes), 32'd10);
    wb(1, 16'hffac, 16'h0000); return_from_service_instr();
    test_done();
  end
endmodule
